// >>> logic/smb_cfg_pkg.sv
// Purpose: shared constants and types for the smbus configuration port
// Assumes: 8-bit register bytes, 7-bit target address plus direction bit
// Notes:   tri-level strap coding is low=0, mid=1, high=2
package smb_cfg_pkg;
  localparam int          PAIRS        = 19;
  localparam logic [7:0]  IDX_CTRL0    = 8'h00;
  localparam logic [7:0]  IDX_OE_LOW   = 8'h01;
  localparam logic [7:0]  IDX_OE_MID   = 8'h02;
  localparam logic [7:0]  IDX_IDENT    = 8'h05;
  localparam logic [7:0]  IDX_DEVID    = 8'h06;
  localparam logic [7:0]  IDX_COUNT    = 8'h07;
  localparam logic [4:0]  COUNT_RESET  = 5'h08;
  localparam logic [2:0]  CTRL0_EN_RST = 3'h7;
  localparam logic [7:0]  OE_RST       = 8'hFF;
  localparam int          CTRL0_EN_LSB = 3;
  // tri-level pin codes
  typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH} tri_level_e;
  // strap latch results carried together
  typedef struct packed {
    logic [1:0] pll_mode;
    logic       input_frequency_select;
  } straps_s;
  // 8-bit addresses, index = 3*a1 + a0
  localparam logic [7:0] ADDR_TABLE [9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4,
                                            8'hC6, 8'hCA, 8'hCC, 8'hCE};
  // pll mode readback for low, mid, high pin levels
  localparam logic [1:0] MODE_LOW = 2'h0;
  localparam logic [1:0] MODE_MID = 2'h1;
  localparam logic [1:0] MODE_HI  = 2'h3;
endpackage

// >>> logic/smb_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination is mclk_i
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module smb_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0  // idle level of the pins after reset
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // double register against metastability
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RST;
      q_o    <= RST;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // smb_sync
`default_nettype wire

// >>> logic/smb_cfg_port.sv
// Purpose: smbus target port holding the output-enable configuration bytes
// Assumes: scl/sda oversampled on mclk_i; straps stable at reset release
// Notes:   block write/read with byte count; no clock stretching
`timescale 1ns/10ps
`default_nettype none
module smb_cfg_port
  import smb_cfg_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h0, // arbitrary value
  parameter logic [3:0] VENDOR_CODE   = 4'h5, // arbitrary value
  parameter logic [7:0] DEVICE_CODE   = 8'h5A // arbitrary value
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  input  wire smb_cfg_pkg::tri_level_e addr_strap1_i,
  input  wire smb_cfg_pkg::tri_level_e addr_strap0_i,
  input  wire smb_cfg_pkg::tri_level_e pll_mode_pin_i,
  input  wire logic                 input_frequency_select_i,
  input  wire logic [PAIRS-1:0]     hw_enable_i,
  output logic      [PAIRS-1:0]     pair_run_o
);
  import smb_cfg_pkg::*;
  // the register map serves exactly nineteen pairs
  if (PAIRS != 19) begin : g_bad_pairs
    $error("pair count must be 19");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA,
                            ST_RDATA, ST_IGNORE} state_e;

  // pins cross into mclk_i
  logic [1:0] bus_s;
  logic [6:0] pin_s;
  // bus copies reset to the released level so no false edge follows reset
  smb_sync #(.W(2), .RST(2'b11)) u_bus (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .d_i({scl_i, sda_i}), .q_o(bus_s));
  smb_sync #(.W(7)) u_pins (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .d_i({addr_strap1_i, addr_strap0_i, pll_mode_pin_i, input_frequency_select_i}),
    .q_o(pin_s));
  logic [PAIRS-1:0] hwen_s;
  smb_sync #(.W(PAIRS)) u_hwen (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .d_i(hw_enable_i), .q_o(hwen_s));

  // straps caught once after reset release
  logic       latched_q;
  straps_s    straps_q;
  logic [7:0] addr_q;
  logic [3:0] addr_idx;
  logic [1:0] mode_dec;
  always_comb begin
    addr_idx = 4'(3 * int'(pin_s[6:5]) + int'(pin_s[4:3]));
    unique case (pin_s[2:1])
      TRI_LOW: mode_dec = MODE_LOW;
      TRI_MID: mode_dec = MODE_MID;
      default: mode_dec = MODE_HI;
    endcase
  end
  logic [1:0] settle_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_q  <= 2'h0;
      latched_q <= 1'b0;
      straps_q  <= '0;
      addr_q    <= ADDR_TABLE[0];
    end else if (!latched_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == 2'h3) begin
        latched_q <= 1'b1;
        straps_q  <= '{pll_mode: mode_dec, input_frequency_select: pin_s[0]};
        addr_q    <= (addr_idx < 4'h9) ? ADDR_TABLE[addr_idx] : ADDR_TABLE[0];
      end
    end
  end

  // bus condition detection on the synchronised copies
  logic scl_q, sda_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus_s[1];
      sda_q <= bus_s[0];
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = bus_s[1] & ~scl_q;
  assign scl_fall = ~bus_s[1] & scl_q;
  assign start_c  = bus_s[1] & scl_q & sda_q & ~bus_s[0];
  assign stop_c   = bus_s[1] & scl_q & ~sda_q & bus_s[0];

  // configuration registers
  logic [2:0]  en_hi_q;
  logic [7:0]  oe_low_q, oe_mid_q;
  logic [4:0]  count_q;
  logic        wr_stb;
  logic [7:0]  idx_q, shift_q;
  // register writes; read-only and reserved bits have no storage
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_hi_q  <= CTRL0_EN_RST;
      oe_low_q <= OE_RST;
      oe_mid_q <= OE_RST;
      count_q  <= COUNT_RESET;
    end else if (wr_stb) begin
      unique case (idx_q)
        IDX_CTRL0:  en_hi_q  <= shift_q[CTRL0_EN_LSB +: 3];
        IDX_OE_LOW: oe_low_q <= shift_q;
        IDX_OE_MID: oe_mid_q <= shift_q;
        IDX_COUNT:  count_q  <= shift_q[4:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped bytes read zero
  logic [7:0] rd_byte, rd_idx;
  always_comb begin
    unique case (rd_idx)
      IDX_CTRL0:  rd_byte = {straps_q.pll_mode, en_hi_q, 2'b00,
                             straps_q.input_frequency_select};
      IDX_OE_LOW: rd_byte = oe_low_q;
      IDX_OE_MID: rd_byte = oe_mid_q;
      IDX_IDENT:  rd_byte = {REVISION_CODE, VENDOR_CODE};
      IDX_DEVID:  rd_byte = DEVICE_CODE;
      IDX_COUNT:  rd_byte = {3'b000, count_q};
      default:    rd_byte = 8'h00;
    endcase
  end

  // pair gating from register and hardware enable
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) pair_run_o <= '0;
    else pair_run_o <= {en_hi_q, oe_mid_q, oe_low_q} & hwen_s;
  end

  // protocol engine
  state_e     st_q;
  logic [3:0] bit_q;
  logic       ack_phase_q, rd_q, drive_q, cnt_sent_q, nack_q;
  logic       byte_done;
  assign byte_done = scl_rise && bit_q == 4'h7 && !ack_phase_q;
  assign wr_stb    = (st_q == ST_WDATA) && scl_fall && ack_phase_q && bit_q == 4'h8;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_IDLE; bit_q <= 4'h0; ack_phase_q <= 1'b0; rd_q <= 1'b0;
      shift_q <= 8'h00; idx_q <= 8'h00; drive_q <= 1'b0; cnt_sent_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (start_c) begin
      st_q <= ST_ADDR; bit_q <= 4'h0; ack_phase_q <= 1'b0; drive_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= ST_IDLE; drive_q <= 1'b0;
    end else if (st_q != ST_IDLE && st_q != ST_IGNORE) begin
      if (!ack_phase_q && st_q != ST_RDATA && scl_rise) begin
        shift_q <= {shift_q[6:0], bus_s[0]};
        bit_q   <= bit_q + 4'h1;
      end
      if (byte_done && st_q != ST_RDATA) begin
        ack_phase_q <= 1'b1;
        bit_q <= 4'h8;
      end
      // drive ack after the eighth bit, release after ninth clock
      if (ack_phase_q && scl_fall && bit_q == 4'h8) begin
        if (st_q == ST_ADDR && shift_q[7:1] != addr_q[7:1]) begin
          st_q <= ST_IGNORE;
        end else begin
          drive_q <= 1'b1;
          bit_q   <= 4'h9;
        end
      end else if (ack_phase_q && scl_fall && bit_q == 4'h9) begin
        drive_q <= 1'b0; ack_phase_q <= 1'b0; bit_q <= 4'h0;
        unique case (st_q)
          ST_ADDR: begin
            rd_q <= shift_q[0];
            if (shift_q[0]) begin
              st_q <= ST_RDATA; cnt_sent_q <= 1'b0;
              shift_q <= {3'b000, count_q}; drive_q <= 1'b1; // count msb is zero
            end else st_q <= ST_INDEX;
          end
          ST_INDEX: begin idx_q <= shift_q; st_q <= ST_COUNT; end
          ST_COUNT: st_q <= ST_WDATA;
          ST_WDATA: idx_q <= idx_q + 8'h01;
          default: ;
        endcase
      end
      // transmit: sda changes on falling scl
      if (st_q == ST_RDATA) begin
        if (!ack_phase_q) begin
          drive_q <= ~shift_q[7];
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              ack_phase_q <= 1'b1; drive_q <= 1'b0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end else begin
          drive_q <= 1'b0;
          if (scl_rise) nack_q <= bus_s[0];
          if (scl_fall && !nack_q) begin
            ack_phase_q <= 1'b0; bit_q <= 4'h0;
            if (cnt_sent_q) idx_q <= idx_q + 8'h01;
            cnt_sent_q <= 1'b1;
            shift_q <= rd_byte;
          end else if (scl_fall) begin
            st_q <= ST_IGNORE;
          end
        end
      end
    end
  end
  // once the count is out, each load comes from the index being stepped to
  assign rd_idx = (st_q == ST_RDATA && cnt_sent_q) ? idx_q + 8'h01 : idx_q;
  // open-drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_q;

  chk_nack_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (st_q == ST_IGNORE) |-> !sda_oe_o) else $error("sda held after nack");
  chk_pair_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !hwen_s[0] |=> !pair_run_o[0]) else $error("pair ran while disabled");
  chk_count_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> count_q == COUNT_RESET) else $error("count reset");
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    rd_idx == IDX_CTRL0 |-> rd_byte[2:1] == 2'b00) else $error("reserved bits");
  chk_ack_only_drive: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (st_q != ST_RDATA && !ack_phase_q) |-> !sda_oe_o) else $error("sda driven outside ack");
  chk_low_store: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (wr_stb && idx_q == IDX_OE_LOW) |=> oe_low_q == $past(shift_q))
    else $error("output enable byte not stored");
  chk_count_first: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(st_q == ST_RDATA) |-> shift_q == {3'b000, count_q})
    else $error("count byte not sent first");
  cov_write: cover property (@(posedge mclk_i) wr_stb);
  cov_read: cover property (@(posedge mclk_i) st_q == ST_RDATA);
  cov_ignore: cover property (@(posedge mclk_i) st_q == ST_IGNORE);
endmodule // smb_cfg_port
`default_nettype wire

// >>> tb/smb_host_model.sv
// Purpose: behavioural smbus host driving scl and pulling sda low
// Assumes: sda has a pull-up; scl half-period of 6 mclk cycles
// Notes:   reports each ack seen or byte read on res_o
`timescale 1ns/10ps
`default_nettype none
module smb_host_model (
  input  wire logic       mclk_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_low_o,
  output logic            res_valid_o,
  output logic [7:0]      res_o
);
  // idle bus: both lines released, scl stands high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    res_valid_o = 1'b0;
    res_o = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one-cycle result pulse
  task automatic emit(input logic [7:0] v);
    res_o <= v;
    res_valid_o <= 1'b1;
    wt(1);
    res_valid_o <= 1'b0;
  endtask
  // start or repeated start, sda falls while scl high
  task automatic start();
    wt(6);
    sda_low_o <= 1'b0;
    wt(6);
    scl_o <= 1'b1;
    wt(6);
    sda_low_o <= 1'b1;
    wt(6);
    scl_o <= 1'b0;
  endtask
  // stop, sda rises while scl high
  task automatic stop();
    wt(6);
    sda_low_o <= 1'b1;
    wt(6);
    scl_o <= 1'b1;
    wt(6);
    sda_low_o <= 1'b0;
    wt(6);
  endtask
  // data moves mid-low so it never changes under a high scl
  task automatic bit_io(input logic b, output logic r);
    wt(3);
    sda_low_o <= ~b;
    wt(3);
    scl_o <= 1'b1;
    wt(3);
    r = sda_i;
    wt(3);
    scl_o <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    emit({7'h00, ~r});
  endtask
  // host acks all but the last byte
  task automatic rbyte(input logic last);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
    emit(v);
  endtask
endmodule // smb_host_model
`default_nettype wire

// >>> tb/tb_smbus_clock_buffer_config_port.sv
// Purpose: self-checking bench for the smbus configuration port
// Assumes: random straps latched at reset release
// Notes:   results queued by the driver, checked by a watcher
`timescale 1ns/10ps
`default_nettype none
module tb_smbus_clock_buffer_config_port;
  import smb_cfg_pkg::*;
  logic             mclk_i, rstn_i, scl, sda_low, sda_o, sda_oe, res_valid, fs;
  logic [7:0]       res, addr, e, d0, d1, d2;
  logic [1:0]       mode;
  tri_level_e       s1, s0, pm;
  logic [PAIRS-1:0] hw_en, run;
  logic [7:0]       exp_q[$];
  int               num_errors, check_count;
  wire              sda;
  // open drain with pull-up
  assign sda = ~sda_low & (sda_oe ? sda_o : 1'b1);
  smb_host_model host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
    .res_valid_o(res_valid), .res_o(res));
  smb_cfg_port #(.REVISION_CODE(4'h3), .VENDOR_CODE(4'hA), .DEVICE_CODE(8'h6B)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .addr_strap1_i(s1), .addr_strap0_i(s0), .pll_mode_pin_i(pm),
    .input_frequency_select_i(fs), .hw_enable_i(hw_en), .pair_run_o(run));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic err(input string m);
    $display("[ERR] %0t %s", $time, m);
    num_errors++;
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] n, input logic [7:0] d[$]);
    host.start();
    exp_q.push_back(8'h01);
    host.wbyte(addr);
    exp_q.push_back(8'h01);
    host.wbyte(n);
    exp_q.push_back(8'h01);
    host.wbyte(8'(d.size()));
    foreach (d[i]) begin
      exp_q.push_back(8'h01);
      host.wbyte(d[i]);
    end
    host.stop();
  endtask
  // read with count byte c, then bytes d, last one nacked
  task automatic rd(input logic [7:0] n, input logic [7:0] c, input logic [7:0] d[$]);
    host.start();
    repeat (2) exp_q.push_back(8'h01);
    host.wbyte(addr);
    host.wbyte(n);
    host.start();
    exp_q.push_back(8'h01);
    host.wbyte(addr | 8'h01);
    exp_q.push_back(c);
    host.rbyte(1'b0);
    foreach (d[i]) begin
      exp_q.push_back(d[i]);
      host.rbyte(i == d.size() - 1);
    end
    host.stop();
  endtask
  // synchroniser plus output register
  task automatic cmp_run(input logic [PAIRS-1:0] x);
    repeat (6) @(posedge mclk_i);
    check_count++;
    if (run !== x) err("pair run mismatch");
  endtask
  // oldest note against each result
  always @(posedge mclk_i) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) err("unexpected result");
      else begin
        e = exp_q.pop_front();
        check_count++;
        if (res !== e) err("result mismatch");
      end
    end
  end
  initial begin
    num_errors = 0;
    check_count = 0;
    rstn_i = 1'b0;
    hw_en = '1;
    void'($urandom(32'h9808));
    s1 = tri_level_e'($urandom % 3);
    s0 = tri_level_e'($urandom % 3);
    pm = tri_level_e'($urandom % 3);
    fs = 1'($urandom);
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    addr = ADDR_TABLE[3 * s1 + s0];
    mode = (pm == TRI_LOW) ? MODE_LOW : (pm == TRI_MID) ? MODE_MID : MODE_HI;
    rd(8'h00, 8'h08, '{{mode, 3'h7, 2'h0, fs}, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h3A, 8'h6B,
      8'h08});
    hw_en <= PAIRS'($urandom);
    @(posedge mclk_i);
    cmp_run(hw_en);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    wr(8'h00, '{d0, d1, d2});
    cmp_run({d0[5:3], d2, d1} & hw_en);
    rd(8'h00, 8'h08, '{{mode, d0[5:3], 2'h0, fs}, d1, d2});
    wr(IDX_COUNT, '{8'h02});
    rd(8'h01, 8'h02, '{d1, d2});
    // second reset with fresh straps: every byte returns to its default
    s1 <= tri_level_e'($urandom % 3);
    s0 <= tri_level_e'($urandom % 3);
    pm <= tri_level_e'($urandom % 3);
    fs <= 1'($urandom);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    addr = ADDR_TABLE[3 * s1 + s0];
    mode = (pm == TRI_LOW) ? MODE_LOW : (pm == TRI_MID) ? MODE_MID : MODE_HI;
    cmp_run(hw_en);
    rd(8'h00, 8'h08, '{{mode, 3'h7, 2'h0, fs}, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h3A, 8'h6B,
      8'h08});
    // wrong address is left unanswered
    host.start();
    exp_q.push_back(8'h00);
    host.wbyte(addr ^ 8'h02);
    host.stop();
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge mclk_i);
    if (exp_q.size() != 0) err("results missing");
    report_and_stop();
  end
endmodule // tb_smbus_clock_buffer_config_port
`default_nettype wire
